// >>> include/drfoc_pkg.sv
/*
  Package for the host-side controller that drives an asynchronous
  1M x 16 DRAM: pin bundles, modes, states and timing counts.
  Assumes a 125 MHz system clock.
*/
package drfoc_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned POWERUP_PAUSE_US = 200;
  localparam int unsigned POWERUP_PAUSE_CYC = POWERUP_PAUSE_US * CLK_MHZ;
  localparam int unsigned INIT_CYCLES = 8;
  localparam int unsigned SELF_REFRESH_MIN_US = 100;
  localparam int unsigned SELF_REFRESH_CYC = SELF_REFRESH_MIN_US * CLK_MHZ;
  localparam int unsigned REFRESH_WINDOW_12_MS = 64;
  localparam int unsigned REFRESH_WINDOW_10_MS = 16;
  localparam int unsigned REFRESH_WINDOW_LP_MS = 128;
  localparam int unsigned ROWS_12 = 4096;
  localparam int unsigned ROWS_10 = 1024;
  // Interval between distributed refreshes: window / rows, rounded down
  localparam int unsigned REFRESH_INT_12_CYC =
    (REFRESH_WINDOW_12_MS * 1000 * CLK_MHZ) / ROWS_12;
  localparam int unsigned REFRESH_INT_10_CYC =
    (REFRESH_WINDOW_10_MS * 1000 * CLK_MHZ) / ROWS_10;
  // Battery backup periods in ns (31.25 us and 125 us), rounded down
  localparam int unsigned BACKUP_PERIOD_12_NS = 31250;
  localparam int unsigned BACKUP_PERIOD_10_NS = 125000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned BACKUP_PERIOD_12_CYC = BACKUP_PERIOD_12_NS / CLK_PERIOD_NS;
  localparam int unsigned BACKUP_PERIOD_10_CYC = BACKUP_PERIOD_10_NS / CLK_PERIOD_NS;
  // Row strobe low in backup must stay below 300 ns: half the longest time, round down
  localparam int unsigned BACKUP_RAS_MAX_NS = 300;
  localparam int unsigned BACKUP_RAS_CYC = (BACKUP_RAS_MAX_NS / CLK_PERIOD_NS) / 2;
  // Per-phase strobe time (precharge, setup, strobe low) for plain cycles
  localparam int unsigned PHASE_NS = 60;
  localparam int unsigned PHASE_CYC = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic        row_strobe_n;
    logic        low_byte_column_strobe_n;
    logic        high_byte_column_strobe_n;
    logic        write_strobe_n;
    logic        output_enable_n;
    logic [11:0] address_pins;
  } drfoc_pins_type;

  typedef enum logic [1:0] {
    DRFOC_CMD_READ = 2'h0,
    DRFOC_CMD_WRITE = 2'h1,
    DRFOC_CMD_HIDDEN = 2'h2
  } drfoc_cmd_type;

  typedef struct packed {
    drfoc_cmd_type cmd;
    logic [19:0]   addr;
    logic [1:0]    byte_en;
    logic [15:0]   wdata;
  } drfoc_req_type;

  typedef enum logic [9:0] {
    ST_PWRUP = 10'b00_0000_0001,
    ST_IDLE = 10'b00_0000_0010,
    ST_PRE = 10'b00_0000_0100,
    ST_RAS = 10'b00_0000_1000,
    ST_CAS = 10'b00_0001_0000,
    ST_HID = 10'b00_0010_0000,
    ST_CBR_SETUP = 10'b00_0100_0000,
    ST_CBR_RAS = 10'b00_1000_0000,
    ST_SELF = 10'b01_0000_0000,
    ST_BACKUP = 10'b10_0000_0000
  } drfoc_state_type;

endpackage

// >>> logic/drfoc_ctrl.sv
/*
  Host-side DRAM controller: power-up sequence, reads and writes with
  byte lanes, hidden refresh, distributed column-before-row refresh,
  battery-backup and self-refresh modes, burst refresh on self-refresh exit.
  Assumes the DRAM pins are registered straight to the board and that
  the data bus is resolved outside from data_oe_o.
*/
// Summary of operation
// RULE_01: DRAM floats its data while output enable is high; host then drives.
// RULE_02: DRAM drives data only with row, column and output enable all low.
// RULE_03: DRAM data floats again once output enable or column strobe rises.
// RULE_04: 12-row-bit part: 4096 rows within 64 ms, 128 ms for low-power part.
// RULE_05: 10-row-bit part: 1024 rows within 16 ms, 128 ms for low-power part.
// RULE_06: Ordinary read or write refreshes its selected row.
// RULE_07: Row-only refresh: host gives row address, both column strobes high.
// RULE_08: Hidden refresh: hold column low after read, recycle row strobe.
// RULE_09: Column strobe falling before row strobe means internal-counter refresh.
// RULE_10: Back-to-back column-first refreshes may keep column low, cycling row.
// RULE_11: Backup on 12-row part: refresh every 31.25 us, row low under 300 ns.
// RULE_12: Backup on 10-row part: refresh every 125 us with short row pulses.
// RULE_13: Self-refresh entry: column before row, both low at least 100 us.
// RULE_14: In self-refresh the DRAM refreshes itself with no address.
// RULE_15: Exit self-refresh raising both strobes, then burst refresh all rows.
// RULE_16: After power-up wait 200 us, then at least eight init cycles.
// RULE_17: Init cycles include at least one refresh cycle.
// RULE_18: Low column strobe gates data bits 0-7, high strobe bits 8-15.
// RULE_19: 12-row part latches twelve row bits on row strobe fall.
// RULE_20: DRAM advances its refresh row counter after each internal refresh.
`timescale 1ns/1ps
`default_nettype none
module drfoc_ctrl
  import drfoc_pkg::*;
#(
  parameter int unsigned ROW_BITS = 12,
  parameter bit LOW_POWER = 1'b0,
  parameter int unsigned POWERUP_CYC = POWERUP_PAUSE_CYC,
  parameter int unsigned SELF_MIN_CYC = SELF_REFRESH_CYC
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic req_valid_i,
  input wire drfoc_req_type req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [15:0] rsp_rdata_o,
  input wire logic backup_mode_i,
  input wire logic self_refresh_req_i,
  output logic init_done_o,
  output drfoc_pins_type pins_o,
  input wire logic [15:0] data_pins_i,
  output logic [15:0] data_pins_o,
  output logic [1:0] data_oe_o
);

  // ==========================================================================
  // Derived counts
  // ==========================================================================
  localparam int unsigned NROWS = (ROW_BITS == 12) ? ROWS_12 : ROWS_10;
  localparam int unsigned WINDOW_MS = LOW_POWER ? REFRESH_WINDOW_LP_MS :
    ((ROW_BITS == 12) ? REFRESH_WINDOW_12_MS : REFRESH_WINDOW_10_MS);
  localparam int unsigned REF_INT = (WINDOW_MS * 1000 * CLK_MHZ) / NROWS;
  localparam int unsigned BACKUP_INT =
    (ROW_BITS == 12) ? BACKUP_PERIOD_12_CYC : BACKUP_PERIOD_10_CYC;
  localparam int unsigned CW = 24;

  function automatic logic [CW-1:0] cyc(input int unsigned n);
    cyc = CW'(n);
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  drfoc_state_type st_r, st_nxt;
  drfoc_pins_type pins_r, pins_nxt;
  logic [CW-1:0] tmr_r, tmr_nxt;
  logic [CW-1:0] ref_tmr_r, ref_tmr_nxt;
  logic [12:0] burst_r, burst_nxt;
  logic done_r, done_nxt;
  logic ref_due_r, ref_due_nxt;
  drfoc_req_type req_r, req_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic rsp_r, rsp_nxt;
  logic [1:0] oe_r, oe_nxt;

  wire logic tmr_zero = (tmr_r == '0);

  always_comb begin
    st_nxt = st_r;
    pins_nxt = pins_r;
    tmr_nxt = tmr_zero ? tmr_r : tmr_r - 1'b1;
    ref_tmr_nxt = ref_tmr_r;
    burst_nxt = burst_r;
    done_nxt = done_r;
    ref_due_nxt = ref_due_r;
    req_nxt = req_r;
    rdata_nxt = rdata_r;
    rsp_nxt = 1'b0;
    oe_nxt = oe_r;
    // Distributed refresh pacing; backup mode uses its own period, longer than or equal to the normal one
    if (ref_tmr_r == '0) begin
      ref_tmr_nxt = backup_mode_i ? cyc(BACKUP_INT - 1) : cyc(REF_INT - 1); // RULE_04 RULE_05
      ref_due_nxt = 1'b1;
    end else begin
      ref_tmr_nxt = ref_tmr_r - 1'b1;
    end
    unique case (st_r)
      ST_PWRUP: begin
        if (tmr_zero) begin
          // Eight column-first refresh cycles serve as the init cycles
          burst_nxt = 13'(INIT_CYCLES); // RULE_16 RULE_17
          st_nxt = ST_CBR_SETUP;
          tmr_nxt = cyc(PHASE_CYC);
        end
      end
      ST_IDLE: begin
        pins_nxt.row_strobe_n = 1'b1;
        pins_nxt.low_byte_column_strobe_n = 1'b1;
        pins_nxt.high_byte_column_strobe_n = 1'b1;
        pins_nxt.output_enable_n = 1'b1; // RULE_01
        pins_nxt.write_strobe_n = 1'b1;
        oe_nxt = 2'b00;
        if (tmr_zero) begin
          if (burst_r != '0 || ref_due_r || backup_mode_i) begin
            if (!backup_mode_i || ref_due_r || burst_r != '0) begin
              // A pacing tick in this same cycle must not be lost
              ref_due_nxt = (ref_tmr_r == '0);
              st_nxt = ST_CBR_SETUP;
              tmr_nxt = cyc(PHASE_CYC);
            end
          end else if (self_refresh_req_i && LOW_POWER) begin
            st_nxt = ST_CBR_SETUP;
            tmr_nxt = cyc(PHASE_CYC);
          end else if (req_valid_i) begin
            req_nxt = req_i;
            st_nxt = ST_RAS;
            pins_nxt.address_pins = 12'(req_i.addr[19 -: ROW_BITS]);
            tmr_nxt = cyc(1);
          end
        end
      end
      ST_RAS: begin
        // Row address already settled a cycle earlier; fall latches it
        pins_nxt.row_strobe_n = 1'b0; // RULE_19 RULE_06 RULE_07
        if (tmr_zero) begin
          pins_nxt.address_pins = 12'(req_r.addr[19-ROW_BITS:0]);
          pins_nxt.write_strobe_n = (req_r.cmd != DRFOC_CMD_WRITE);
          oe_nxt = (req_r.cmd == DRFOC_CMD_WRITE) ? req_r.byte_en : 2'b00;
          st_nxt = ST_CAS;
          tmr_nxt = cyc(PHASE_CYC);
        end
      end
      ST_CAS: begin
        pins_nxt.low_byte_column_strobe_n = ~req_r.byte_en[0]; // RULE_18
        pins_nxt.high_byte_column_strobe_n = ~req_r.byte_en[1]; // RULE_18
        pins_nxt.output_enable_n = (req_r.cmd == DRFOC_CMD_WRITE); // RULE_02
        if (tmr_zero) begin
          rdata_nxt = data_pins_i;
          rsp_nxt = 1'b1;
          if (req_r.cmd == DRFOC_CMD_HIDDEN) begin
            // Column and output enable stay low so read data stays valid
            pins_nxt.row_strobe_n = 1'b1; // RULE_08
            st_nxt = ST_HID;
            tmr_nxt = cyc(PHASE_CYC);
          end else begin
            st_nxt = ST_PRE;
            tmr_nxt = cyc(PHASE_CYC);
          end
        end
      end
      ST_HID: begin
        if (tmr_zero && pins_r.row_strobe_n) begin
          pins_nxt.row_strobe_n = 1'b0; // RULE_08 RULE_20
          tmr_nxt = cyc(PHASE_CYC);
        end else if (tmr_zero) begin
          st_nxt = ST_PRE;
          tmr_nxt = cyc(PHASE_CYC);
        end
      end
      ST_PRE: begin
        // Raising column strobe and output enable floats the DRAM outputs
        pins_nxt.row_strobe_n = 1'b1;
        pins_nxt.low_byte_column_strobe_n = 1'b1; // RULE_03
        pins_nxt.high_byte_column_strobe_n = 1'b1;
        pins_nxt.output_enable_n = 1'b1;
        pins_nxt.write_strobe_n = 1'b1;
        oe_nxt = 2'b00;
        if (tmr_zero) begin
          st_nxt = ST_IDLE;
          tmr_nxt = cyc(PHASE_CYC);
        end
      end
      ST_CBR_SETUP: begin
        // Column strobes fall first; row strobe follows after the setup time
        pins_nxt.low_byte_column_strobe_n = 1'b0; // RULE_09
        pins_nxt.high_byte_column_strobe_n = 1'b0;
        pins_nxt.output_enable_n = 1'b1;
        oe_nxt = 2'b00;
        if (tmr_zero) begin
          pins_nxt.row_strobe_n = 1'b0; // RULE_09 RULE_20
          st_nxt = ST_CBR_RAS;
          if (self_refresh_req_i && LOW_POWER && burst_r == '0 && done_r) begin
            st_nxt = ST_SELF;
            tmr_nxt = cyc(SELF_MIN_CYC); // RULE_13
          end else begin
            tmr_nxt = backup_mode_i ? cyc(BACKUP_RAS_CYC) : cyc(PHASE_CYC); // RULE_11 RULE_12
          end
        end
      end
      ST_CBR_RAS: begin
        if (tmr_zero) begin
          pins_nxt.row_strobe_n = 1'b1;
          tmr_nxt = cyc(PHASE_CYC);
          if (burst_r > 13'h0001) begin
            // Column stays low while the row strobe cycles again
            burst_nxt = burst_r - 1'b1; // RULE_10
            st_nxt = ST_CBR_SETUP;
          end else begin
            if (burst_r == 13'h0001) begin
              done_nxt = 1'b1;
            end
            burst_nxt = '0;
            st_nxt = ST_PRE;
          end
        end
      end
      ST_SELF: begin
        // DRAM keeps itself refreshed; address pins are don't-care here
        if (tmr_zero && !self_refresh_req_i) begin // RULE_14
          pins_nxt.row_strobe_n = 1'b1; // RULE_15
          pins_nxt.low_byte_column_strobe_n = 1'b1;
          pins_nxt.high_byte_column_strobe_n = 1'b1;
          burst_nxt = 13'(NROWS); // RULE_15
          st_nxt = ST_PRE;
          tmr_nxt = cyc(PHASE_CYC);
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_r <= ST_PWRUP;
      pins_r <= '{row_strobe_n: 1'b1, low_byte_column_strobe_n: 1'b1,
        high_byte_column_strobe_n: 1'b1, write_strobe_n: 1'b1,
        output_enable_n: 1'b1, address_pins: 12'h0000};
      tmr_r <= cyc(POWERUP_CYC); // RULE_16
      ref_tmr_r <= '0;
      burst_r <= '0;
      done_r <= 1'b0;
      ref_due_r <= 1'b0;
      req_r <= '0;
      rdata_r <= 16'h0000;
      rsp_r <= 1'b0;
      oe_r <= 2'b00;
    end else begin
      st_r <= st_nxt;
      pins_r <= pins_nxt;
      tmr_r <= tmr_nxt;
      ref_tmr_r <= ref_tmr_nxt;
      burst_r <= burst_nxt;
      done_r <= done_nxt;
      ref_due_r <= ref_due_nxt;
      req_r <= req_nxt;
      rdata_r <= rdata_nxt;
      rsp_r <= rsp_nxt;
      oe_r <= oe_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign req_ready_o = (st_r == ST_IDLE) && tmr_zero && done_r && burst_r == '0 &&
    !ref_due_r && !backup_mode_i && !self_refresh_req_i;
  assign rsp_valid_o = rsp_r;
  assign rsp_rdata_o = rdata_r;
  assign init_done_o = done_r;
  assign pins_o = pins_r;
  assign data_pins_o = req_r.wdata;
  assign data_oe_o = oe_r;

endmodule
`default_nettype wire

// >>> bench/drfoc_ctrl_props.sv
/* Checker for the host-side DRAM controller pin sequencing.
   Assumes it is bound onto drfoc_ctrl and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module drfoc_ctrl_props
  import drfoc_pkg::*;
#(
  parameter int unsigned ROW_BITS = 12,
  parameter bit LOW_POWER = 1'b0,
  parameter int unsigned POWERUP_CYC = 20,
  parameter int unsigned SELF_MIN_CYC = 20
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic req_ready_o,
  input wire logic backup_mode_i,
  input wire logic init_done_o,
  input wire drfoc_pins_type pins_o,
  input wire logic [1:0] data_oe_o
);
  // ====================
  // Helper counters
  localparam int unsigned NROWS = 1 << ROW_BITS;
  // Slack lets one access delay a due refresh
  localparam int unsigned GAP_MAX = 64 + (LOW_POWER ? REFRESH_WINDOW_LP_MS :
    (ROW_BITS == 12 ? REFRESH_WINDOW_12_MS : REFRESH_WINDOW_10_MS)) * 1000 * CLK_MHZ / NROWS;
  localparam int unsigned BK_MAX = 64 +
    (ROW_BITS == 12 ? BACKUP_PERIOD_12_CYC : BACKUP_PERIOD_10_CYC);
  logic cas_any, ref_ev, row_q_r, cas_q_r, post_self_r;
  int unsigned since_r, cbr_r, gap_r, low_r, both_r, burst_r;
  assign cas_any = !pins_o.low_byte_column_strobe_n || !pins_o.high_byte_column_strobe_n;
  assign ref_ev = row_q_r && !pins_o.row_strobe_n && cas_q_r;
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      {since_r, cbr_r, gap_r, low_r, both_r, burst_r} <= '0;
      row_q_r <= 1'b1;
      cas_q_r <= 1'b0;
      post_self_r <= 1'b0;
    end else begin
      row_q_r <= pins_o.row_strobe_n;
      cas_q_r <= cas_any;
      since_r <= since_r + 1;
      cbr_r <= cbr_r + ref_ev;
      gap_r <= (!pins_o.row_strobe_n && cas_any) ? 0 : gap_r + 1;
      low_r <= pins_o.row_strobe_n ? 0 : low_r + 1;
      both_r <= (!pins_o.row_strobe_n && cas_any) ? both_r + 1 : 0;
      if (pins_o.row_strobe_n && !row_q_r && both_r > 40) begin
        post_self_r <= 1'b1;
        burst_r <= 0;
      end else begin
        burst_r <= burst_r + ref_ev;
      end
    end
  end
  // ====================
  // Assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  property p_pause; !pins_o.row_strobe_n |-> since_r >= POWERUP_CYC; endproperty
  a_pause: assert property (p_pause) else $error("row strobe inside pause");
  property p_init; $rose(init_done_o) |-> cbr_r >= INIT_CYCLES; endproperty
  a_init: assert property (p_init) else $error("too few init refreshes");
  property p_cbr; $fell(pins_o.row_strobe_n) && cas_any |-> $past(cas_any); endproperty
  a_cbr: assert property (p_cbr) else $error("column strobe not ahead of row");
  property p_bk_ras; backup_mode_i |-> low_r * CLK_PERIOD_NS < BACKUP_RAS_MAX_NS; endproperty
  a_bk_ras: assert property (p_bk_ras) else $error("backup row low too long");
  property p_gap; init_done_o && !backup_mode_i |-> gap_r <= GAP_MAX; endproperty
  a_gap: assert property (p_gap) else $error("refresh interval exceeded");
  property p_bk_gap; backup_mode_i |-> gap_r <= BK_MAX; endproperty
  a_bk_gap: assert property (p_bk_gap) else $error("backup period exceeded");
  property p_self;
    pins_o.row_strobe_n && !row_q_r && both_r > 40 |-> both_r >= SELF_MIN_CYC;
  endproperty
  a_self: assert property (p_self) else $error("self refresh held too short");
  property p_burst; req_ready_o |-> !post_self_r || burst_r >= NROWS; endproperty
  a_burst: assert property (p_burst) else $error("ready before exit burst");
  property p_drive; |data_oe_o |-> pins_o.output_enable_n && !pins_o.write_strobe_n; endproperty
  a_drive: assert property (p_drive) else $error("host drives while outputs on");
endmodule
bind drfoc_ctrl drfoc_ctrl_props #(.ROW_BITS(ROW_BITS), .LOW_POWER(LOW_POWER),
  .POWERUP_CYC(POWERUP_CYC), .SELF_MIN_CYC(SELF_MIN_CYC)) u_props (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .req_ready_o(req_ready_o),
  .backup_mode_i(backup_mode_i), .init_done_o(init_done_o), .pins_o(pins_o),
  .data_oe_o(data_oe_o));
`default_nettype wire

// >>> bench/drfoc_dram_model.sv
/* Behavioural 1M x 16 DRAM with byte lanes and an internal refresh counter.
   Assumes pins change just after the sampling clock edge. */
`timescale 1ns/1ps
`default_nettype none
module drfoc_dram_model
  import drfoc_pkg::*;
#(
  parameter int unsigned ROW_BITS = 10
) (
  input wire logic clk_i,
  input wire drfoc_pins_type pins_i,
  input wire logic [15:0] bus_i,
  output logic [15:0] dq_o
);
  // ====================
  // Array and strobe decode
  logic [15:0] mem [int];
  drfoc_pins_type prev = '1;
  logic cbr = 1'b0;
  logic reading = 1'b0;
  int row = 0;
  int key = 0;
  int rkey = 0;
  int ctr = 0;
  initial dq_o = 16'h0000;
  always @(posedge clk_i) begin
    logic [1:0] lane;
    lane = ~{pins_i.high_byte_column_strobe_n, pins_i.low_byte_column_strobe_n};
    if (prev.row_strobe_n && !pins_i.row_strobe_n) begin
      cbr = !prev.low_byte_column_strobe_n || !prev.high_byte_column_strobe_n;
      if (cbr) begin
        ctr = ctr + 1;
      end else begin
        row = int'(pins_i.address_pins) % (1 << ROW_BITS);
      end
    end
    if (!pins_i.row_strobe_n && !cbr && prev.low_byte_column_strobe_n &&
        prev.high_byte_column_strobe_n && lane != 2'b00) begin
      key = row * (1 << (20 - ROW_BITS)) + int'(pins_i.address_pins) % (1 << (20 - ROW_BITS));
      if (!mem.exists(key)) mem[key] = 16'h0000;
      if (!pins_i.write_strobe_n) begin
        if (lane[0]) mem[key][7:0] = bus_i[7:0];
        if (lane[1]) mem[key][15:8] = bus_i[15:8];
      end else begin
        reading = 1'b1;
        rkey = key;
      end
    end
    // A row strobe cycled under a held column strobe keeps the read data up
    if (lane == 2'b00) reading = 1'b0;
    for (int b = 0; b < 2; b++) begin
      dq_o[b*8 +: 8] <= (reading && lane[b] && !pins_i.output_enable_n) ?
        mem[rkey][b*8 +: 8] : ~dq_o[b*8 +: 8];
    end
    prev = pins_i;
  end
endmodule
`default_nettype wire

// >>> bench/drfoc_ctrl_tb.sv
/* Self-checking bench for drfoc_ctrl against a reference word store.
   Assumes drfoc_dram_model on the pins and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module drfoc_ctrl_tb
  import drfoc_pkg::*;
;
  // ====================
  // Harness
  localparam int unsigned RB = 10;
  logic clk_sys_i = 0, sys_rst_i = 1, req_valid_i = 0, backup_mode_i = 0, self_refresh_req_i = 0;
  drfoc_req_type req_i = '0;
  logic req_ready_o, rsp_valid_o, init_done_o;
  logic [15:0] rsp_rdata_o, data_pins_o, dq, bus;
  logic [1:0] data_oe_o;
  drfoc_pins_type pins_o;
  int err_total = 0, n_tests = 0, cyc = 0;
  logic [31:0] rng = 32'h0000_0cab;
  logic [15:0] ref_mem [int];
  logic [19:0] addrs [$];
  assign bus = {data_oe_o[1] ? data_pins_o[15:8] : dq[15:8],
    data_oe_o[0] ? data_pins_o[7:0] : dq[7:0]};
  drfoc_ctrl #(.ROW_BITS(RB), .LOW_POWER(1'b1), .POWERUP_CYC(20), .SELF_MIN_CYC(200)) uut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
    .backup_mode_i(backup_mode_i), .self_refresh_req_i(self_refresh_req_i),
    .init_done_o(init_done_o), .pins_o(pins_o), .data_pins_i(bus),
    .data_pins_o(data_pins_o), .data_oe_o(data_oe_o));
  drfoc_dram_model #(.ROW_BITS(RB)) u_dram (.clk_i(clk_sys_i), .pins_i(pins_o), .bus_i(bus),
    .dq_o(dq));
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic results();
    $display("Checks %0d, errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ====================
  // Transfers
  task automatic access(input drfoc_cmd_type c, input logic [19:0] a, input logic [1:0] be);
    int n;
    logic [31:0] r;
    r = xs();
    n = 0;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_i <= '{cmd: c, addr: a, byte_en: be, wdata: r[15:0]};
    // Long bound covers the burst after self refresh
    do begin @(negedge clk_sys_i); n++; end while (req_ready_o !== 1'b1 && n < 70000);
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 40) begin @(negedge clk_sys_i); n++; end
    `CHK("rsp_valid", 1'b1, rsp_valid_o)
    if (c == DRFOC_CMD_WRITE) begin
      if (!ref_mem.exists(a)) ref_mem[a] = 16'h0000;
      if (be[0]) ref_mem[a][7:0] = r[7:0];
      if (be[1]) ref_mem[a][15:8] = r[15:8];
    end else begin
      `CHK("rdata", ref_mem[a], rsp_rdata_o)
    end
  endtask
  task automatic read_all();
    foreach (addrs[i]) access(i % 2 ? DRFOC_CMD_HIDDEN : DRFOC_CMD_READ, addrs[i], 2'b11);
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      results();
    end
  end
  initial begin
    int n;
    logic [31:0] r;
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    n = 0;
    while (init_done_o !== 1'b1 && n < 5000) begin @(negedge clk_sys_i); n++; end
    `CHK("init_done", 1'b1, init_done_o)
    for (int i = 0; i < 8; i++) begin
      r = xs();
      addrs.push_back(i == 0 ? 20'h0_0000 : i == 1 ? 20'hf_ffff : r[19:0]);
      access(DRFOC_CMD_WRITE, addrs[i], 2'(i % 3 + 1));
    end
    read_all();
    @(posedge clk_sys_i);
    backup_mode_i <= 1'b1;
    repeat (16000) @(posedge clk_sys_i);
    backup_mode_i <= 1'b0;
    read_all();
    @(posedge clk_sys_i);
    self_refresh_req_i <= 1'b1;
    repeat (400) @(posedge clk_sys_i);
    self_refresh_req_i <= 1'b0;
    read_all();
    results();
  end
endmodule
`default_nettype wire
